// >>> rtl/cpwm_pkg.sv
// Package for the complementary PWM extras and the timer event-request logic.
// Assumes a 32-bit APB slave with byte addresses and a 40 MHz peripheral clock.
package cpwm_pkg;

  // ----------------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------------
  localparam logic [7:0] OFS_ACCESS   = 8'h00;
  localparam logic [7:0] OFS_OUT_CTRL = 8'h04;
  localparam logic [7:0] OFS_GATE     = 8'h08;
  localparam logic [7:0] OFS_SYNC     = 8'h0C;
  localparam logic [7:0] OFS_CYCLE    = 8'h10;
  localparam logic [7:0] OFS_DUTY_U   = 8'h14;
  localparam logic [7:0] OFS_DUTY_V   = 8'h18;
  localparam logic [7:0] OFS_DUTY_W   = 8'h1C;
  localparam logic [7:0] OFS_STATUS   = 8'h20;
  localparam logic [7:0] OFS_IRQ_EN   = 8'h24;
  localparam logic [7:0] OFS_REQ_SEL  = 8'h28;
  localparam logic [7:0] OFS_STATE    = 8'h2C;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int ACC_EN_BIT      = 0;
  localparam int OC_MODE_BIT     = 0;
  localparam int OC_POS_LVL_BIT  = 1;
  localparam int OC_NEG_LVL_BIT  = 2;
  localparam int OC_TOGGLE_BIT   = 3;
  localparam int GC_POS_LSB      = 0;
  localparam int GC_FB_BIT       = 3;
  localparam int GC_PCHOP_BIT    = 4;
  localparam int GC_NCHOP_BIT    = 5;
  localparam int GC_BDC_BIT      = 6;
  localparam int SY_SYNC_BIT     = 0;
  localparam int SY_CLR_LSB      = 1;
  localparam int RS_DMA_LSB      = 0;
  localparam int RS_ADC_LSB      = 5;
  localparam int NUM_CH          = 5;
  localparam int NUM_SRC         = 6;
  localparam int NUM_FLAGS       = NUM_CH * NUM_SRC;

  // Source slot inside a channel: A, B, C, D, overflow, underflow
  localparam int SRC_A = 0;

  // ----------------------------------------------------------------------
  // Reset values and encodings
  // ----------------------------------------------------------------------
  localparam logic [31:0] ACCESS_RST   = 32'h0000_0001;
  localparam logic [2:0]  CLR_SEL_SYNC = 3'h3;
  localparam logic [15:0] DUTY_ZERO    = 16'h0000;
  localparam logic [15:0] CNT_ZERO     = 16'h0000;
  // Sources present per channel, channel 0 in the low six bits
  localparam logic [NUM_FLAGS-1:0] FLAG_MASK =
    {6'h1F, 6'h1F, 6'h33, 6'h33, 6'h1F};

  // Commutation table, index {w,v,u}; result {wn,vn,un,wp,vp,up}
  localparam logic [5:0] COMMUTE [8] = '{
    6'h00, 6'h21, 6'h0A, 6'h22, 6'h14, 6'h0C, 6'h11, 6'h00};

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic unf;
    logic ovf;
    logic d;
    logic c;
    logic b;
    logic a;
  } cpwm_evt_s;

endpackage : cpwm_pkg

// >>> rtl/cpwm_evt.sv
// Complementary PWM extras (0/100% duty, carrier toggle, sync clear, brushless
// commutation, six-phase output protection) and timer event requests (irq, DMA, A/D).
// Assumes the counter core supplies counts and per-source event pulses.
//
// Register access over APB and the register addresses are this design's own decisions.
`timescale 1ns/1ps
module cpwm_evt #(
  parameter int CNT_W = 16
) (
  // Clock and reset
  input  wire logic                          clk,
  input  wire logic                          rst_b,
  // APB slave
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [7:0]                    paddr,
  input  wire logic [31:0]                   pwdata,
  output logic      [31:0]                   prdata,
  output logic                               pready,
  output logic                               pslverr,
  // Counter core
  input  wire logic [CNT_W-1:0]              ch3_counter,
  input  wire logic [CNT_W-1:0]              ch4_counter,
  input  wire logic                          other_channel_clear,
  input  wire cpwm_pkg::cpwm_evt_s [4:0]     timer_events,
  output logic                               clear_counters,
  // Position inputs and gate drivers
  input  wire logic                          ch0_position_input_a,
  input  wire logic                          ch0_position_input_b,
  input  wire logic                          ch0_position_input_c,
  input  wire logic [3:0]                    output_disable_b,
  output logic      [5:0]                    phase_out,
  output logic      [5:0]                    phase_oe,
  output logic                               ch3_a_timer_pin_out,
  output logic                               ch3_a_timer_pin_oe,
  // Event requests
  output logic      [cpwm_pkg::NUM_FLAGS-1:0] irq_req,
  output logic                               irq_any,
  output logic      [4:0]                    irq_top_id,
  output logic      [4:0]                    dma_req,
  input  wire logic [4:0]                    dma_ack,
  output logic      [4:0]                    adc_start_req
);

  localparam int NF = cpwm_pkg::NUM_FLAGS;

  // ----------------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------------
  logic             access_q;
  logic [3:0]       out_ctrl_q;
  logic [6:0]       gate_q;
  logic [3:0]       sync_q;
  logic [CNT_W-1:0] cycle_q;
  logic [CNT_W-1:0] duty_q [3];
  logic [NF-1:0]    flags_q;
  logic [NF-1:0]    seen_q;
  logic [NF-1:0]    irq_en_q;
  logic [9:0]       req_sel_q;
  logic             wr_en;
  logic             rd_en;
  logic             prot_sel;
  logic             mapped;
  logic             mode_en;
  logic             pos_lvl;
  logic             neg_lvl;
  logic             tog_en;
  logic             fb_sel;
  logic             pchop;
  logic             nchop;
  logic             bdc_en;
  assign mode_en = out_ctrl_q[cpwm_pkg::OC_MODE_BIT];
  assign pos_lvl = out_ctrl_q[cpwm_pkg::OC_POS_LVL_BIT];
  assign neg_lvl = out_ctrl_q[cpwm_pkg::OC_NEG_LVL_BIT];
  assign tog_en  = out_ctrl_q[cpwm_pkg::OC_TOGGLE_BIT];
  assign fb_sel  = gate_q[cpwm_pkg::GC_FB_BIT];
  assign pchop   = gate_q[cpwm_pkg::GC_PCHOP_BIT];
  assign nchop   = gate_q[cpwm_pkg::GC_NCHOP_BIT];
  assign bdc_en  = gate_q[cpwm_pkg::GC_BDC_BIT];

  // ----------------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------------
  // Zero-wait slave: every access completes in its first access cycle
  assign pready = 1'b1;
  assign wr_en  = psel & penable & pwrite;
  assign rd_en  = psel & penable & ~pwrite;

  always_comb begin
    prot_sel = 1'b0;
    mapped   = 1'b1;
    case (paddr)
      cpwm_pkg::OFS_OUT_CTRL, cpwm_pkg::OFS_GATE, cpwm_pkg::OFS_SYNC,
      cpwm_pkg::OFS_CYCLE, cpwm_pkg::OFS_DUTY_U, cpwm_pkg::OFS_DUTY_V,
      cpwm_pkg::OFS_DUTY_W: prot_sel = 1'b1;
      cpwm_pkg::OFS_ACCESS, cpwm_pkg::OFS_STATUS, cpwm_pkg::OFS_IRQ_EN,
      cpwm_pkg::OFS_REQ_SEL, cpwm_pkg::OFS_STATE: prot_sel = 1'b0;
      default: mapped = 1'b0;
    endcase
  end

  assign pslverr = psel & penable & ~mapped;
  // Protected registers ignore writes while locked
  logic prot_wr;
  assign prot_wr = wr_en & prot_sel & access_q;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      access_q <= cpwm_pkg::ACCESS_RST[0];
    end else if (wr_en && paddr == cpwm_pkg::OFS_ACCESS) begin
      access_q <= pwdata[cpwm_pkg::ACC_EN_BIT];
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      out_ctrl_q <= 4'h0;
      gate_q     <= 7'h00;
      sync_q     <= 4'h0;
      cycle_q    <= '0;
      duty_q     <= '{default: '0};
    end else if (prot_wr) begin
      case (paddr)
        cpwm_pkg::OFS_OUT_CTRL: out_ctrl_q <= pwdata[3:0];
        cpwm_pkg::OFS_GATE:     gate_q     <= pwdata[6:0];
        cpwm_pkg::OFS_SYNC:     sync_q     <= pwdata[3:0];
        cpwm_pkg::OFS_CYCLE:    cycle_q    <= pwdata[CNT_W-1:0];
        cpwm_pkg::OFS_DUTY_U:   duty_q[0]  <= pwdata[CNT_W-1:0];
        cpwm_pkg::OFS_DUTY_V:   duty_q[1]  <= pwdata[CNT_W-1:0];
        cpwm_pkg::OFS_DUTY_W:   duty_q[2]  <= pwdata[CNT_W-1:0];
        default:                ;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_en_q  <= '0;
      req_sel_q <= 10'h000;
    end else if (wr_en && paddr == cpwm_pkg::OFS_IRQ_EN) begin
      irq_en_q  <= pwdata[NF-1:0] & cpwm_pkg::FLAG_MASK;
    end else if (wr_en && paddr == cpwm_pkg::OFS_REQ_SEL) begin
      req_sel_q <= pwdata[9:0];
    end
  end

  // ----------------------------------------------------------------------
  // Duty compare and phase waveform
  // ----------------------------------------------------------------------
  logic [2:0] pwm_q;
  logic       ch3_cycle_hit;
  logic       ch4_zero_hit;
  assign ch3_cycle_hit = ch3_counter == cycle_q;
  assign ch4_zero_hit  = ch4_counter == CNT_W'(cpwm_pkg::CNT_ZERO);

  for (genvar p = 0; p < 3; p++) begin : g_phase
    logic on_hit;
    logic off_hit;
    // Off timing follows the leading counter, on timing the lagging one
    assign off_hit = ch3_counter == duty_q[p];
    assign on_hit  = ch4_counter == duty_q[p];

    always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
        pwm_q[p] <= 1'b0;
      end else if (!mode_en) begin
        pwm_q[p] <= 1'b0;
      end else if (duty_q[p] == CNT_W'(cpwm_pkg::DUTY_ZERO)) begin
        pwm_q[p] <= 1'b1;
      end else if (duty_q[p] == cycle_q) begin
        pwm_q[p] <= 1'b0;
      end else if (on_hit && off_hit) begin
        pwm_q[p] <= pwm_q[p];
      end else if (off_hit) begin
        pwm_q[p] <= 1'b0;
      end else if (on_hit) begin
        pwm_q[p] <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Brushless commutation pattern
  // ----------------------------------------------------------------------
  logic [2:0] pos_src;
  logic [2:0] pos_last_q;
  logic [5:0] pattern_q;
  // Any change of the selected source counts as an edge
  assign pos_src = fb_sel ? gate_q[cpwm_pkg::GC_POS_LSB +: 3]
                          : {ch0_position_input_c, ch0_position_input_b,
                             ch0_position_input_a};

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pos_last_q <= 3'h0;
      pattern_q  <= 6'h00;
    end else if (pos_src != pos_last_q) begin
      pos_last_q <= pos_src;
      pattern_q  <= cpwm_pkg::COMMUTE[pos_src];
    end
  end

  // ----------------------------------------------------------------------
  // Six-phase pins
  // ----------------------------------------------------------------------
  logic       disable_hit;
  logic [5:0] phase_on;
  // Disable is a low level on any input
  assign disable_hit = ~&output_disable_b;

  for (genvar p = 0; p < 3; p++) begin : g_drive
    always_comb begin
      if (bdc_en) begin
        phase_on[p]   = pattern_q[p] & (pchop ? pwm_q[p] : 1'b1);
        phase_on[p+3] = pattern_q[p+3] & (nchop ? ~pwm_q[p] : 1'b1);
      end else begin
        phase_on[p]   = pwm_q[p];
        phase_on[p+3] = ~pwm_q[p];
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      phase_out <= 6'h00;
      phase_oe  <= 6'h00;
    end else begin
      phase_out <= {phase_on[5:3] ~^ {3{neg_lvl}},
                    phase_on[2:0] ~^ {3{pos_lvl}}};
      phase_oe  <= {6{mode_en & ~disable_hit}};
    end
  end

  // ----------------------------------------------------------------------
  // Carrier-synchronous toggle
  // ----------------------------------------------------------------------
  logic tog_active;
  logic tog_active_q;
  logic toggle_q;
  assign tog_active = mode_en & tog_en;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tog_active_q <= 1'b0;
      toggle_q     <= 1'b1;
    end else begin
      tog_active_q <= tog_active;
      if (tog_active && !tog_active_q) begin
        toggle_q <= 1'b1;
      end else if (tog_active && (ch3_cycle_hit ^ ch4_zero_hit)) begin
        toggle_q <= ~toggle_q;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ch3_a_timer_pin_out <= 1'b0;
      ch3_a_timer_pin_oe  <= 1'b0;
    end else begin
      ch3_a_timer_pin_out <= toggle_q;
      ch3_a_timer_pin_oe  <= tog_active_q;
    end
  end

  // ----------------------------------------------------------------------
  // Synchronous clearing by another channel
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      clear_counters <= 1'b0;
    end else begin
      clear_counters <= mode_en & sync_q[cpwm_pkg::SY_SYNC_BIT]
                      & (sync_q[cpwm_pkg::SY_CLR_LSB +: 3] == cpwm_pkg::CLR_SEL_SYNC)
                      & other_channel_clear;
    end
  end

  // ----------------------------------------------------------------------
  // Status flags
  // ----------------------------------------------------------------------
  logic [NF-1:0] ev_set;
  logic [NF-1:0] sw_clr;
  logic [NF-1:0] dma_clr;
  logic [4:0]    a_set;

  always_comb begin
    ev_set = timer_events & cpwm_pkg::FLAG_MASK;
    // In complementary mode the cycle-limit match also sets the ch3 A source
    if (mode_en && ch3_cycle_hit) begin
      ev_set[3*cpwm_pkg::NUM_SRC + cpwm_pkg::SRC_A] = 1'b1;
    end
  end

  for (genvar c = 0; c < cpwm_pkg::NUM_CH; c++) begin : g_chan
    assign a_set[c]   = ev_set[c*cpwm_pkg::NUM_SRC + cpwm_pkg::SRC_A];
    assign dma_clr[c*cpwm_pkg::NUM_SRC +: cpwm_pkg::NUM_SRC] =
      {5'h00, dma_ack[c] & dma_req[c]};
    assign dma_req[c] = flags_q[c*cpwm_pkg::NUM_SRC + cpwm_pkg::SRC_A]
                      & req_sel_q[cpwm_pkg::RS_DMA_LSB + c];
  end

  // Only flags read as 1 may be cleared by a written 0
  assign sw_clr = (wr_en && paddr == cpwm_pkg::OFS_STATUS)
                ? (~pwdata[NF-1:0] & seen_q) : '0;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      flags_q <= '0;
    end else begin
      flags_q <= (flags_q & ~sw_clr & ~dma_clr) | ev_set;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      seen_q <= '0;
    end else if (rd_en && paddr == cpwm_pkg::OFS_STATUS) begin
      seen_q <= seen_q | flags_q;
    end else begin
      seen_q <= seen_q & flags_q & ~sw_clr;
    end
  end

  // ----------------------------------------------------------------------
  // Interrupt, DMA and A/D requests
  // ----------------------------------------------------------------------
  assign irq_req = flags_q & irq_en_q;
  assign irq_any = |irq_req;

  always_comb begin
    irq_top_id = 5'h00;
    // Lowest index wins: channel 0 source A first
    for (int i = NF - 1; i >= 0; i--) begin
      if (irq_req[i]) begin
        irq_top_id = 5'(i);
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      adc_start_req <= 5'h00;
    end else begin
      adc_start_req <= a_set & req_sel_q[cpwm_pkg::RS_ADC_LSB +: 5]
                     & (mode_en ? 5'h0F : 5'h1F);
    end
  end

  // ----------------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------------
  always_comb begin
    prdata = 32'h0000_0000;
    if (rd_en && !(prot_sel && !access_q)) begin
      case (paddr)
        cpwm_pkg::OFS_ACCESS:   prdata = {31'h0, access_q};
        cpwm_pkg::OFS_OUT_CTRL: prdata = {28'h0, out_ctrl_q};
        cpwm_pkg::OFS_GATE:     prdata = {25'h0, gate_q};
        cpwm_pkg::OFS_SYNC:     prdata = {28'h0, sync_q};
        cpwm_pkg::OFS_CYCLE:    prdata = 32'(cycle_q);
        cpwm_pkg::OFS_DUTY_U:   prdata = 32'(duty_q[0]);
        cpwm_pkg::OFS_DUTY_V:   prdata = 32'(duty_q[1]);
        cpwm_pkg::OFS_DUTY_W:   prdata = 32'(duty_q[2]);
        cpwm_pkg::OFS_STATUS:   prdata = {2'h0, flags_q};
        cpwm_pkg::OFS_IRQ_EN:   prdata = {2'h0, irq_en_q};
        cpwm_pkg::OFS_REQ_SEL:  prdata = {22'h0, req_sel_q};
        cpwm_pkg::OFS_STATE:    prdata = {17'h0, disable_hit, toggle_q,
                                          pos_last_q, pwm_q, 1'b0, pattern_q};
        default:                prdata = 32'h0000_0000;
      endcase
    end
  end

endmodule : cpwm_evt

// >>> testbench/cpwm_evt_sva.sv
// Checker for the PWM extras and event requests, bound to the block.
// Sees only the top module's ports; one clock domain.
`timescale 1ns/1ps
module cpwm_evt_sva (
  // Clock and reset
  input wire logic                           clk,
  input wire logic                           rst_b,
  // Observed ports
  input wire logic                           psel,
  input wire logic                           pwrite,
  input wire logic                           other_channel_clear,
  input wire cpwm_pkg::cpwm_evt_s [4:0]      timer_events,
  input wire logic                           clear_counters,
  input wire logic [3:0]                     output_disable_b,
  input wire logic [5:0]                     phase_oe,
  input wire logic                           ch3_a_timer_pin_out,
  input wire logic                           ch3_a_timer_pin_oe,
  input wire logic [cpwm_pkg::NUM_FLAGS-1:0] irq_req,
  input wire logic                           irq_any,
  input wire logic [4:0]                     irq_top_id,
  input wire logic [4:0]                     dma_req,
  input wire logic [4:0]                     dma_ack,
  input wire logic [4:0]                     adc_start_req
);
  logic [2:0] evt_a;

  assign evt_a = {timer_events[2].a, timer_events[1].a, timer_events[0].a};

  // Lowest pending index wins
  function automatic logic [4:0] first_set(input logic [29:0] v);
    first_set = 5'h00;
    for (int i = 29; i >= 0; i--)
      if (v[i]) first_set = 5'(i);
  endfunction : first_set

  // ----------------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  // A software write may drop the request
  sequence s_dma_wait;
    dma_req[0] && !dma_ack[0] && !(psel && pwrite);
  endsequence
  sequence s_dma_taken;
    dma_req[0] && dma_ack[0] && !timer_events[0].a;
  endsequence

  a_irq_summary: assert property (irq_any == (|irq_req))
    else $error("irq summary mismatch");
  a_top_priority: assert property (irq_any |-> irq_top_id == first_set(irq_req))
    else $error("wrong top priority source");
  a_no_phantom: assert property ((irq_req & ~cpwm_pkg::FLAG_MASK) == '0)
    else $error("request from absent source");
  a_dma_held: assert property (s_dma_wait |=> dma_req[0])
    else $error("dma request dropped early");
  a_dma_ack_clear: assert property (s_dma_taken |=> !dma_req[0])
    else $error("dma request kept after ack");
  a_adc_cause: assert property ((adc_start_req[2:0] & ~$past(evt_a)) == 3'h0)
    else $error("conversion start without event");
  a_hiz_on_fault: assert property (output_disable_b != 4'hF |=> phase_oe == 6'h00)
    else $error("phases driven during fault");
  a_clear_cause: assert property (clear_counters |-> $past(other_channel_clear))
    else $error("counter clear without cause");
  a_toggle_entry: assert property ($rose(ch3_a_timer_pin_oe) |-> ch3_a_timer_pin_out)
    else $error("toggle does not start high");
endmodule : cpwm_evt_sva

bind cpwm_evt cpwm_evt_sva cpwm_evt_sva_i (
  .clk(clk), .rst_b(rst_b), .psel(psel), .pwrite(pwrite),
  .other_channel_clear(other_channel_clear), .timer_events(timer_events),
  .clear_counters(clear_counters), .output_disable_b(output_disable_b),
  .phase_oe(phase_oe), .ch3_a_timer_pin_out(ch3_a_timer_pin_out),
  .ch3_a_timer_pin_oe(ch3_a_timer_pin_oe), .irq_req(irq_req), .irq_any(irq_any),
  .irq_top_id(irq_top_id), .dma_req(dma_req), .dma_ack(dma_ack),
  .adc_start_req(adc_start_req));

// >>> testbench/cpwm_drv_model.sv
// Model of the gate drivers and rotor position sensors around the block.
// Assumes the bench steps the rotor and injects faults through its inputs.
`timescale 1ns/1ps
module cpwm_drv_model (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_b,
  // Bench controls
  input  wire logic       hall_step,
  input  wire logic [3:0] fault,
  // Block side
  input  wire logic [5:0] phase_out,
  input  wire logic [5:0] phase_oe,
  output logic            pos_a,
  output logic            pos_b,
  output logic            pos_c,
  output logic [3:0]      output_disable_b,
  output logic [5:0]      gate_level
);
  localparam logic [2:0] HALL [6] = '{3'h1, 3'h3, 3'h2, 3'h6, 3'h4, 3'h5};
  logic [2:0] step_q;
  logic [5:0] last_q;

  // Six-step sensor sequence, one sensor edge per step
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) step_q <= 3'h0;
    else if (hall_step) step_q <= (step_q == 3'h5) ? 3'h0 : step_q + 3'h1;
  end
  assign {pos_c, pos_b, pos_a} = HALL[step_q];
  // Fault lines are active-low levels
  assign output_disable_b = ~fault;
  // A released gate line flips so stale levels never look valid
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) last_q <= 6'h00;
    else last_q <= gate_level;
  end
  assign gate_level = (phase_oe & phase_out) | (~phase_oe & ~last_q);
endmodule : cpwm_drv_model

// >>> testbench/test_complementary_pwm_event_logic.sv
// Self-checking bench for the PWM extras and timer event requests.
// Assumes package, block, checker and driver model compile first.
`timescale 1ns/1ps
module test_complementary_pwm_event_logic;
  logic                      clk, rst_b, psel, penable, pwrite, pready, pslverr;
  logic                      other_channel_clear, clear_counters, hall_step;
  logic                      pos_a, pos_b, pos_c, pin_out, pin_oe, irq_any;
  logic [7:0]                paddr;
  logic [31:0]               pwdata, prdata, dv;
  logic [15:0]               ch3_counter, ch4_counter;
  logic [3:0]                fault, output_disable_b;
  logic [5:0]                phase_out, phase_oe, gate_level;
  logic [4:0]                irq_top_id, dma_req, dma_ack, adc_start_req;
  logic [29:0]               irq_req;
  cpwm_pkg::cpwm_evt_s [4:0] timer_events;
  logic [31:0]               exp_q[$];
  int                        num_errors, check_count, seed, idx;

  cpwm_evt cpwm_evt_i (
    .clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ch3_counter(ch3_counter), .ch4_counter(ch4_counter), .timer_events(timer_events),
    .other_channel_clear(other_channel_clear), .clear_counters(clear_counters),
    .ch0_position_input_a(pos_a), .ch0_position_input_b(pos_b),
    .ch0_position_input_c(pos_c), .output_disable_b(output_disable_b),
    .phase_out(phase_out), .phase_oe(phase_oe), .ch3_a_timer_pin_out(pin_out),
    .ch3_a_timer_pin_oe(pin_oe), .irq_req(irq_req), .irq_any(irq_any),
    .irq_top_id(irq_top_id), .dma_req(dma_req), .dma_ack(dma_ack),
    .adc_start_req(adc_start_req));
  cpwm_drv_model cpwm_drv_model_i (
    .clk(clk), .rst_b(rst_b), .hall_step(hall_step), .fault(fault),
    .phase_out(phase_out), .phase_oe(phase_oe), .pos_a(pos_a), .pos_b(pos_b),
    .pos_c(pos_c), .output_disable_b(output_disable_b), .gate_level(gate_level));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // ----------------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------------
  task automatic chk(input logic [31:0] exp, input logic [31:0] got, input string what);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic print_verdict(input logic hung);
    if (hung) num_errors++;
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : print_verdict

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 40);
    if (pready !== 1'b1) print_verdict(1'b1);
    {psel, penable} <= 2'b00;
  endtask : apb

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask : rd

  task automatic pulse(input logic [29:0] v);
    @(posedge clk);
    timer_events <= v;
    @(posedge clk);
    timer_events <= 30'h0;
    @(posedge clk);
  endtask : pulse

  // Oldest note is compared as each read completes
  always @(posedge clk) begin
    if (psel && penable && pready === 1'b1) begin
      chk({31'h0, paddr > 8'h2C}, {31'h0, pslverr}, "error response");
      if (!pwrite) chk(exp_q.pop_front(), prdata, "read data");
    end
  end

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    {psel, penable, pwrite, hall_step, other_channel_clear, rst_b} = '0;
    {paddr, pwdata, dma_ack, fault, timer_events} = '0;
    {ch3_counter, ch4_counter} = 32'h0001_0001;
    seed = 18;
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    rd(cpwm_pkg::OFS_ACCESS, cpwm_pkg::ACCESS_RST);
    rd(8'h30, 32'h0);
    dv = {16'h0, 16'($random(seed))};
    apb(1'b1, cpwm_pkg::OFS_DUTY_U, dv);
    apb(1'b1, cpwm_pkg::OFS_ACCESS, 32'h0);
    apb(1'b1, cpwm_pkg::OFS_DUTY_U, ~dv);
    rd(cpwm_pkg::OFS_DUTY_U, 32'h0);
    apb(1'b1, cpwm_pkg::OFS_ACCESS, 32'h1);
    rd(cpwm_pkg::OFS_DUTY_U, dv);
    apb(1'b1, cpwm_pkg::OFS_IRQ_EN, 32'h3FFF_FFFF);
    for (idx = 0; idx < 30; idx++) begin
      pulse(30'h1 << idx);
      chk({31'h0, cpwm_pkg::FLAG_MASK[idx]}, {31'h0, irq_any}, "irq");
      rd(cpwm_pkg::OFS_STATUS, {2'b00, cpwm_pkg::FLAG_MASK & (30'h1 << idx)});
      apb(1'b1, cpwm_pkg::OFS_STATUS, 32'h0);
      rd(cpwm_pkg::OFS_STATUS, 32'h0);
    end
    pulse(30'h1 << 13 | 30'h1 << 28);
    chk(32'd13, {27'h0, irq_top_id}, "top source");
    apb(1'b1, cpwm_pkg::OFS_STATUS, 32'h0);
    rd(cpwm_pkg::OFS_STATUS, 32'h1000_2000);
    apb(1'b1, cpwm_pkg::OFS_IRQ_EN, 32'h0);
    @(posedge clk);
    chk(32'h0, {31'h0, irq_any}, "masked irq");
    apb(1'b1, cpwm_pkg::OFS_STATUS, 32'h0);
    apb(1'b1, cpwm_pkg::OFS_REQ_SEL, 32'h0000_03FF);
    pulse(30'h43);
    chk(32'h3, {27'h0, adc_start_req}, "adc start");
    chk(32'h3, {27'h0, dma_req}, "dma request");
    repeat (3) @(posedge clk);
    chk(32'h3, {27'h0, dma_req}, "dma held");
    dma_ack <= 5'h01;
    @(posedge clk);
    dma_ack <= 5'h00;
    @(posedge clk);
    chk(32'h2, {27'h0, dma_req}, "dma after ack");
    rd(cpwm_pkg::OFS_STATUS, 32'h0000_0042);
    apb(1'b1, cpwm_pkg::OFS_OUT_CTRL, 32'h0000_0007);
    apb(1'b1, cpwm_pkg::OFS_SYNC, {28'h0, cpwm_pkg::CLR_SEL_SYNC, 1'b1});
    other_channel_clear <= 1'b1;
    @(posedge clk);
    other_channel_clear <= 1'b0;
    @(posedge clk);
    chk(32'h1, {31'h0, clear_counters}, "counter clear");
    apb(1'b1, cpwm_pkg::OFS_CYCLE, 32'h0000_0040);
    apb(1'b1, cpwm_pkg::OFS_OUT_CTRL, 32'h0000_000F);
    repeat (3) @(posedge clk);
    chk(32'h1, {31'h0, pin_out}, "toggle entry");
    ch3_counter <= 16'h0040;
    @(posedge clk);
    ch3_counter <= 16'h0041;
    repeat (2) @(posedge clk);
    chk(32'h0, {31'h0, pin_out}, "toggle at limit");
    ch4_counter <= 16'h0000;
    @(posedge clk);
    ch4_counter <= 16'h0001;
    repeat (2) @(posedge clk);
    chk(32'h1, {31'h0, pin_out}, "toggle at zero");
    apb(1'b1, cpwm_pkg::OFS_GATE, 32'h0000_0040);
    repeat (6) begin
      hall_step <= 1'b1;
      @(posedge clk);
      hall_step <= 1'b0;
      repeat (4) @(posedge clk);
      chk({26'h0, cpwm_pkg::COMMUTE[{pos_c, pos_b, pos_a}]}, {26'h0, phase_out}, "hall");
    end
    apb(1'b1, cpwm_pkg::OFS_GATE, 32'h0000_004D);
    repeat (3) @(posedge clk);
    chk({26'h0, cpwm_pkg::COMMUTE[5]}, {26'h0, phase_out}, "soft pattern");
    fault <= 4'h4;
    repeat (2) @(posedge clk);
    chk(32'h0, {26'h0, phase_oe}, "outputs released");
    print_verdict(1'b0);
  end
endmodule : test_complementary_pwm_event_logic
